/* core/liu_host_port.sv */
// Purpose: Host port pins of an octal line interface: serial, parallel and hardware modes.
// Assumes: All host pins are asynchronous to CLK; the host shift clock is much slower.
// Notes: A 32-entry byte register file stands behind the host port and APB window.
//
// Overview of operation
// R1: Serial write keeps serial output tristated.
// R2: Serial read tristates only during command byte.
// R3: Output shifts on falling or rising per select.
// R4: Ready high ends cycle, low inserts waits.
// R5: Acknowledge low marks read valid or write taken.
// R6: Open-drain active-low interrupt from four source pins plus host write and parallel host read events.
// R7: Loop pins pick remote, none or analog.
// R8: Plain parallel mode uses pins as data bus.
// R9: Multiplexed mode shares pins for address and data.
// R10: Serial mode boards ground the shared pins.
// R11: Latch strobe fall captures low five address bits.
// R12: Serial input sampled on shift-clock rising edges.
// R13: Write data captured on write strobe rising edge.
// R14: Shared pins driven only during reads.
`timescale 1ns/1ps
module liu_host_port #(
  parameter int ADDR_W = 5,
  parameter int CHANNELS = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CS_N,
  input wire logic SCLK_LATCH_IN,
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_IN,
  input wire logic READ_STROBE,
  input wire logic WRITE_STROBE,
  input wire logic OUT_EDGE_SELECT,
  input wire logic [ADDR_W-1:0] ADDR_PINS,
  input wire logic [CHANNELS-1:0] BUS_IN,
  output logic [CHANNELS-1:0] BUS_OUT,
  output logic [CHANNELS-1:0] BUS_OE,
  input wire logic [CHANNELS-1:0] LOOP_MID_LEVEL,
  output logic [2*CHANNELS-1:0] LOOP_MODE,
  output logic SHARED_OUT,
  output logic SHARED_OE,
  input wire logic [3:0] INT_SOURCES,
  output logic INT_N_OUT,
  output logic INT_N_OE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Three-level loop pin: the mid-level comparator overrides the logic level.
  function automatic logic [1:0] loop_decode(input logic level, input logic mid);
    loop_decode = mid ? liu_host_port_pkg::LOOP_NONE :
                  (level ? liu_host_port_pkg::LOOP_ANALOG : liu_host_port_pkg::LOOP_REMOTE);
  endfunction : loop_decode

  function automatic logic is_mux(input liu_host_port_pkg::host_mode_t m);
    is_mux = (m == liu_host_port_pkg::MODE_RDY_MUX) || (m == liu_host_port_pkg::MODE_ACK_MUX);
  endfunction : is_mux

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  liu_host_port_pkg::pin_group_t pins_meta, pins_s, pins_d, pins_now;
  logic [CHANNELS-1:0] bus_meta, bus_s, mid_meta, mid_s;
  logic [ADDR_W-1:0] addr_meta, addr_s;

  assign pins_now = '{cs_n: CS_N, sclk: SHIFT_CLK, sdi: SERIAL_IN, latch: SCLK_LATCH_IN,
                      rd: READ_STROBE, wr: WRITE_STROBE, edge_sel: OUT_EDGE_SELECT};

  // Two stages for every pin except INT_SOURCES; a third copy of the strobes feeds edge detection only.
  always_ff @(posedge CLK) begin
    pins_meta <= pins_now;
    pins_s <= pins_meta;
    pins_d <= pins_s;
    bus_meta <= BUS_IN;
    bus_s <= bus_meta;
    mid_meta <= LOOP_MID_LEVEL;
    mid_s <= mid_meta;
    addr_meta <= ADDR_PINS;
    addr_s <= addr_meta;
  end

  // ----------------------------------------------------------------
  // Mode and decode
  // ----------------------------------------------------------------
  logic [2:0] ctrl_mode;
  liu_host_port_pkg::host_mode_t mode;
  logic serial_mode, rdy_style, ack_style, parallel_mode;
  logic sclk_rise, sclk_fall, out_edge, latch_fall;
  logic rd_lvl, wr_lvl, rd_lvl_d, wr_lvl_d, rd_start, wr_end;

  assign mode = (ctrl_mode > 3'h5) ? liu_host_port_pkg::MODE_HARDWARE :
                liu_host_port_pkg::host_mode_t'(ctrl_mode);
  assign serial_mode = (mode == liu_host_port_pkg::MODE_SERIAL);
  assign rdy_style = (mode == liu_host_port_pkg::MODE_RDY_PLAIN) || (mode == liu_host_port_pkg::MODE_RDY_MUX);
  assign ack_style = (mode == liu_host_port_pkg::MODE_ACK_PLAIN) || (mode == liu_host_port_pkg::MODE_ACK_MUX);
  assign parallel_mode = rdy_style || ack_style;
  assign sclk_rise = pins_s.sclk && !pins_d.sclk;
  assign sclk_fall = !pins_s.sclk && pins_d.sclk;
  assign out_edge = pins_s.edge_sel ? sclk_fall : sclk_rise; // [R3]
  assign latch_fall = !pins_s.latch && pins_d.latch;
  // The strobe pins mean read/write strobes, or direction plus data strobe.
  assign rd_lvl = !pins_s.cs_n && (rdy_style ? !pins_s.rd : (ack_style && !pins_s.wr && pins_s.rd));
  assign wr_lvl = !pins_s.cs_n && (rdy_style ? !pins_s.wr : (ack_style && !pins_s.wr && !pins_s.rd));
  assign rd_start = rd_lvl && !rd_lvl_d;
  assign wr_end = wr_lvl_d && !wr_lvl; // [R13]

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_lvl_d <= 1'b0;
      wr_lvl_d <= 1'b0;
    end else begin
      rd_lvl_d <= rd_lvl;
      wr_lvl_d <= wr_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Parallel address capture
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_latch, par_addr;

  // Only the low address bits are kept; the upper bus bits are ignored by design.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      addr_latch <= '0;
    end else if (is_mux(mode) && latch_fall) begin
      addr_latch <= bus_s[ADDR_W-1:0]; // [R11] [R9]
    end
  end

  assign par_addr = is_mux(mode) ? addr_latch : addr_s;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  liu_host_port_pkg::ser_state_t ser_state;
  logic [3:0] bit_cnt;
  logic [7:0] cmd_shift, ser_shift;
  logic ser_read, ser_started, ser_bit, ser_commit;
  logic [ADDR_W-1:0] ser_addr;
  logic [7:0] regfile [32];

  assign ser_commit = ser_state == liu_host_port_pkg::SER_DATA && !ser_read && sclk_rise
                      && bit_cnt == liu_host_port_pkg::SER_DATA_LAST;

  // Frame ends whenever chip select rises, so a short frame is simply dropped.
  always_ff @(posedge CLK) begin
    if (!RST_N || !serial_mode || pins_s.cs_n) begin
      ser_state <= liu_host_port_pkg::SER_IDLE;
      bit_cnt <= 4'h0;
      cmd_shift <= 8'h00;
      ser_shift <= 8'h00;
      ser_read <= 1'b0;
      ser_started <= 1'b0;
      ser_bit <= 1'b0;
    end else begin
      unique case (ser_state)
        liu_host_port_pkg::SER_IDLE: begin
          ser_state <= liu_host_port_pkg::SER_CMD;
        end
        liu_host_port_pkg::SER_CMD: begin
          if (sclk_rise) begin
            cmd_shift <= {cmd_shift[6:0], pins_s.sdi}; // [R12]
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == liu_host_port_pkg::SER_CMD_LAST) begin
              ser_state <= liu_host_port_pkg::SER_DATA;
              ser_read <= cmd_shift[liu_host_port_pkg::SER_READ_BIT-1];
              ser_shift <= regfile[{cmd_shift[ADDR_W-2:0], pins_s.sdi}];
            end
          end
        end
        liu_host_port_pkg::SER_DATA: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (!ser_read) begin
              ser_shift <= {ser_shift[6:0], pins_s.sdi}; // [R12]
            end
          end
          if (ser_read && out_edge) begin
            ser_started <= 1'b1; // [R3]
            ser_bit <= ser_started ? ser_shift[6] : ser_shift[7];
            if (ser_started) begin
              ser_shift <= {ser_shift[6:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  assign ser_addr = cmd_shift[ADDR_W-1:0];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic apb_done, apb_file_hit;
  logic [ADDR_W-1:0] apb_index;

  assign apb_done = PSEL && PENABLE && PREADY;
  assign apb_file_hit = PADDR >= liu_host_port_pkg::ADDR_FILE_BASE
                        && PADDR < liu_host_port_pkg::ADDR_FILE_LIMIT;
  assign apb_index = PADDR[ADDR_W+1:2];

  // Host writes win over a same-cycle APB write; the APB write is then lost.
  always_ff @(posedge CLK) begin
    if (ser_commit) begin
      regfile[ser_addr] <= {ser_shift[6:0], pins_s.sdi};
    end else if (parallel_mode && wr_end) begin
      regfile[par_addr] <= bus_s; // [R13] [R8] [R9]
    end else if (apb_done && PWRITE && apb_file_hit) begin
      regfile[apb_index] <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Parallel handshake and shared pins
  // ----------------------------------------------------------------
  logic rd_wait, ack_n;

  // Two wait cycles cover the file lookup before data is claimed valid.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_wait <= 1'b0;
      ack_n <= 1'b1;
      BUS_OUT <= '0;
      BUS_OE <= '0;
    end else begin
      rd_wait <= rdy_style && rd_start; // [R4]
      ack_n <= !(ack_style && ((rd_lvl && rd_lvl_d) || wr_lvl)); // [R5]
      BUS_OE <= {CHANNELS{parallel_mode && rd_lvl}}; // [R14] [R8] [R9]
      if (rd_start) begin
        BUS_OUT <= regfile[par_addr];
      end
    end
  end

  // Shared output pin: serial data, ready, acknowledge, or idle in hardware mode.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SHARED_OUT <= 1'b1;
      SHARED_OE <= 1'b0;
    end else begin
      SHARED_OE <= parallel_mode ||
                   (serial_mode && ser_state == liu_host_port_pkg::SER_DATA && ser_read); // [R1] [R2]
      if (serial_mode) begin
        SHARED_OUT <= ser_bit; // [R3]
      end else if (rdy_style) begin
        SHARED_OUT <= !(rd_start || rd_wait); // [R4]
      end else if (ack_style) begin
        SHARED_OUT <= ack_n; // [R5]
      end else begin
        SHARED_OUT <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware loopback select
  // ----------------------------------------------------------------
  // Outside hardware mode the pins are bus lines, so the last selection is held.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LOOP_MODE <= '0;
    end else if (mode == liu_host_port_pkg::MODE_HARDWARE) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        LOOP_MODE[2*ch +: 2] <= loop_decode(bus_s[ch], mid_s[ch]); // [R7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [3:0] src_d;
  logic [5:0] int_status, int_mask, int_set, int_clr;

  assign int_set = {rd_start && parallel_mode, ser_commit || (parallel_mode && wr_end),
                    INT_SOURCES & ~src_d};
  assign int_clr = (apb_done && PWRITE && PADDR == liu_host_port_pkg::ADDR_INT_STATUS) ?
                   PWDATA[5:0] : 6'h00;

  // A new event in the clearing cycle survives: set wins over clear.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      src_d <= 4'h0;
      int_status <= 6'h00;
      INT_N_OE <= 1'b0;
    end else begin
      src_d <= INT_SOURCES;
      int_status <= (int_status & ~int_clr) | int_set; // [R6]
      INT_N_OE <= |(int_status & int_mask); // [R6]
    end
  end

  assign INT_N_OUT = 1'b0;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] last_addr;
  logic [7:0] last_data;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      last_addr <= '0;
      last_data <= 8'h00;
    end else if (ser_commit) begin
      last_addr <= ser_addr;
      last_data <= {ser_shift[6:0], pins_s.sdi};
    end else if (parallel_mode && wr_end) begin
      last_addr <= par_addr;
      last_data <= bus_s;
    end
  end

  // Each access takes exactly one wait state so read data comes from a flop.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      ctrl_mode <= liu_host_port_pkg::CTRL_RESET;
      int_mask <= liu_host_port_pkg::INT_MASK_RESET;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= 32'h0000_0000;
        unique case (PADDR)
          liu_host_port_pkg::ADDR_CTRL: PRDATA[2:0] <= ctrl_mode;
          liu_host_port_pkg::ADDR_LOOP: PRDATA[2*CHANNELS-1:0] <= LOOP_MODE;
          liu_host_port_pkg::ADDR_INT_STATUS: PRDATA[5:0] <= int_status;
          liu_host_port_pkg::ADDR_INT_MASK: PRDATA[5:0] <= int_mask;
          liu_host_port_pkg::ADDR_HOST_LAST: PRDATA[15:0] <= {last_data, 3'h0, last_addr};
          default: begin
            if (apb_file_hit) begin
              PRDATA[7:0] <= regfile[apb_index];
            end else begin
              PSLVERR <= 1'b1;
            end
          end
        endcase
      end
      if (apb_done && PWRITE && PADDR == liu_host_port_pkg::ADDR_CTRL) begin
        ctrl_mode <= PWDATA[2:0];
      end
      if (apb_done && PWRITE && PADDR == liu_host_port_pkg::ADDR_INT_MASK) begin
        int_mask <= PWDATA[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_ser_write_hiz;
    serial_mode && ser_state == liu_host_port_pkg::SER_DATA && !ser_read |=> !SHARED_OE;
  endproperty
  a_ser_write_hiz: assert property (p_ser_write_hiz) else $error("serial out driven in write"); // [R1]

  property p_ser_cmd_hiz;
    serial_mode && ser_state == liu_host_port_pkg::SER_CMD |=> !SHARED_OE;
  endproperty
  a_ser_cmd_hiz: assert property (p_ser_cmd_hiz) else $error("serial out driven in command"); // [R2]

  property p_ser_edge;
    serial_mode && !pins_s.cs_n && !out_edge |=> $stable(ser_bit);
  endproperty
  a_ser_edge: assert property (p_ser_edge) else $error("serial bit moved off its edge"); // [R3]

  property p_rdy_wait;
    rdy_style && rd_start ##1 rdy_style |-> !SHARED_OUT ##1 !SHARED_OUT ##1 SHARED_OUT;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready wait window wrong"); // [R4]

  property p_ack_read;
    ack_style && rd_lvl && rd_lvl_d |=> ##1 !SHARED_OUT;
  endproperty
  a_ack_read: assert property (p_ack_read) else $error("acknowledge missing on read"); // [R5]

  property p_int_out;
    (|(int_status & int_mask)) |=> INT_N_OE && !INT_N_OUT;
  endproperty
  a_int_out: assert property (p_int_out) else $error("interrupt not asserted"); // [R6]

  property p_loop_mid;
    mode == liu_host_port_pkg::MODE_HARDWARE && mid_s[0] |=> LOOP_MODE[1:0] == liu_host_port_pkg::LOOP_NONE;
  endproperty
  a_loop_mid: assert property (p_loop_mid) else $error("mid level not decoded"); // [R7]

  property p_bus_oe;
    !(parallel_mode && rd_lvl) |=> BUS_OE == '0;
  endproperty
  a_bus_oe: assert property (p_bus_oe) else $error("bus driven outside read"); // [R14]

  property p_addr_latch;
    is_mux(mode) && latch_fall |=> addr_latch == $past(bus_s[ADDR_W-1:0]);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // [R11]

  property p_sdi_sample;
    serial_mode && !pins_s.cs_n && ser_state == liu_host_port_pkg::SER_CMD && sclk_rise
      |=> cmd_shift[0] == $past(pins_s.sdi);
  endproperty
  a_sdi_sample: assert property (p_sdi_sample) else $error("serial input not sampled"); // [R12]

endmodule : liu_host_port

/* core/liu_host_port_pkg.sv */
// Purpose: Shared constants and types for the line interface host port pin logic.
// Assumes: Registers sit on a 32-bit APB bus, one aligned word each.
// Notes: Host mode codes double as the mode field of the control register.
package liu_host_port_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_LOOP = 12'h004;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INT_MASK = 12'h00C;
  localparam logic [11:0] ADDR_HOST_LAST = 12'h010;
  localparam logic [11:0] ADDR_FILE_BASE = 12'h080;
  localparam logic [11:0] ADDR_FILE_LIMIT = 12'h100;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 3;
  localparam int INT_SRC_COUNT = 4;
  localparam int INT_BIT_HOST_WRITE = 4;
  localparam int INT_BIT_HOST_READ = 5;
  localparam int INT_W = 6;
  localparam int LAST_DATA_LSB = 8;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [5:0] INT_MASK_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int SER_READ_BIT = 7;
  localparam logic [3:0] SER_CMD_LAST = 4'h7;
  localparam logic [3:0] SER_DATA_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Per-channel loopback codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LOOP_NONE = 2'h0;
  localparam logic [1:0] LOOP_REMOTE = 2'h1;
  localparam logic [1:0] LOOP_ANALOG = 2'h2;

  // Host interface styles; unused codes fall back to hardware control.
  typedef enum logic [2:0] {
    MODE_HARDWARE, MODE_SERIAL, MODE_RDY_PLAIN, MODE_RDY_MUX, MODE_ACK_PLAIN, MODE_ACK_MUX
  } host_mode_t;

  typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA} ser_state_t;

  // Strobe and clock pins that pass through the synchroniser together.
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
    logic latch;
    logic rd;
    logic wr;
    logic edge_sel;
  } pin_group_t;

endpackage : liu_host_port_pkg

/* testbench/liu_host_model.sv */
// Purpose: Behavioural host driving the serial and parallel host pins.
// Assumes: Pins change right after a rising clk edge; a shift phase is 4 clk.
// Notes: The shared bus level is resolved here from both enables.
`timescale 1ns/1ps
module liu_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic latch,
  output logic sclk,
  output logic sdi,
  output logic rd_pin,
  output logic wr_pin,
  output logic edge_sel,
  output logic [4:0] addr,
  output logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe,
  input wire logic shared_out,
  input wire logic shared_oe
);
  logic [7:0] drv = 8'h00;
  logic drv_en = 1'b1;
  logic watch = 1'b0;
  logic [1:0] seen = 2'h0;
  wire serial_out = shared_oe ? shared_out : 1'bz;
  initial {cs_n, latch, sclk, sdi, rd_pin, wr_pin, edge_sel, addr} = {7'h67, 5'h00};

  // ------------------------------------------------------------
  // Wire level and enable watch
  // ------------------------------------------------------------
  // A released host leaves no stale value: the inverse of its last drive shows.
  always_comb for (int i = 0; i < 8; i++) bus_in[i] = bus_oe[i] ? bus_out[i] : drv[i] ^ !drv_en;
  // Records any output enable seen while a transfer is watched.
  always @(posedge clk) seen <= watch ? seen | {shared_oe, |bus_oe} : 2'h0;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  task automatic set_bus(input logic [7:0] v);
    drv <= v;
    drv_en <= 1'b1;
  endtask : set_bus

  // Stretches the high phase after the command so the turnaround is settled.
  task automatic ser_frame(input logic rd, input logic [4:0] a, input logic [7:0] d,
      input logic es, output logic [7:0] q, output logic [1:0] oe);
    logic [15:0] w;
    w = {rd, 2'h0, a, d};
    watch <= 1'b1;
    edge_sel <= es;
    cs_n <= 1'b0;
    wait_clk(4);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= w[i];
      wait_clk(4);
      if (!es && i < 7) q[i + 1] = serial_out;
      sclk <= 1'b1;
      if (i == 8 && rd) oe = seen;
      wait_clk(i == 8 ? 12 : 4);
      if (es && i < 8) q[i] = serial_out;
    end
    wait_clk(4);
    q[0] = es ? q[0] : serial_out;
    oe = rd ? oe : seen;
    {sclk, watch} <= 2'h0;
    wait_clk(4);
    cs_n <= 1'b1;
    wait_clk(8);
  endtask : ser_frame

  task automatic par_xfer(input logic [2:0] m, input logic rd, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic [1:0] oe);
    int n;
    logic low;
    {n, low} = 0;
    watch <= 1'b1;
    addr <= a;
    if (m[0]) begin
      set_bus({3'h7, a});
      wait_clk(2);
      latch <= 1'b0;
      wait_clk(4);
      latch <= 1'b1;
    end
    if (rd) drv_en <= 1'b0;
    else set_bus(d);
    // Chip select frames the strobe; without it the port ignores the cycle.
    if (m[2]) {cs_n, rd_pin, wr_pin} <= {1'b0, rd, 1'b0};
    else {cs_n, rd_pin, wr_pin} <= {1'b0, !rd, rd};
    // Wait states and acknowledge are honoured before the strobe ends.
    do begin
      wait_clk(1);
      n++;
      low = low | (shared_oe && !shared_out);
    end while (!(m[2] ? low : (!rd || (low && shared_out))));
    if (n < 6) wait_clk(6 - n);
    q = bus_in;
    {cs_n, rd_pin, wr_pin} <= 3'h7;
    wait_clk(2);
    drv_en <= 1'b0;
    wait_clk(8);
    oe = seen;
    watch <= 1'b0;
  endtask : par_xfer
endmodule : liu_host_model

/* testbench/liu_host_port_tb.sv */
// Purpose: Self-checking bench for the host port pins.
// Assumes: APB answers in its own time; host pins are driven by the model.
// Notes: Expectations come from the pin rules and package constants only.
`timescale 1ns/1ps
module liu_host_port_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic cs_n, latch, sclk, sdi, rd_pin, wr_pin, edge_sel, shared_out, shared_oe;
  logic [4:0] addr_pins, a;
  logic [7:0] bus_in, bus_out, bus_oe, mid, q, lv;
  logic [15:0] loop_mode, exp_loop;
  logic [3:0] int_src;
  logic int_n_out, int_n_oe;
  logic [1:0] oe;
  int err_total, num_checks;

  liu_host_port dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CS_N(cs_n), .SCLK_LATCH_IN(latch), .SHIFT_CLK(sclk),
    .SERIAL_IN(sdi), .READ_STROBE(rd_pin), .WRITE_STROBE(wr_pin),
    .OUT_EDGE_SELECT(edge_sel), .ADDR_PINS(addr_pins), .BUS_IN(bus_in), .BUS_OUT(bus_out),
    .BUS_OE(bus_oe), .LOOP_MID_LEVEL(mid), .LOOP_MODE(loop_mode), .SHARED_OUT(shared_out),
    .SHARED_OE(shared_oe), .INT_SOURCES(int_src), .INT_N_OUT(int_n_out),
    .INT_N_OE(int_n_oe));
  liu_host_model host (.clk(clk), .cs_n(cs_n), .latch(latch), .sclk(sclk), .sdi(sdi),
    .rd_pin(rd_pin), .wr_pin(wr_pin), .edge_sel(edge_sel), .addr(addr_pins),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .shared_out(shared_out),
    .shared_oe(shared_oe));

  // ------------------------------------------------------------
  // Clock, tasks and verdict
  // ------------------------------------------------------------
  // The 40 MHz clock.
  always #12.5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Holds the request until pready is sampled high; no latency is assumed.
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, ad, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // A hang is cut short at 16000 cycles, well beyond the expected run of some 800 cycles.
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata, mid, int_src} = 0;
    {err_total, num_checks} = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("int_n_oe", 0, 32'(int_n_oe));
    chk("shared_oe", 0, 32'(shared_oe));
    // Hardware mode: low, mid and high levels on the loop pins.
    // Two complementary patterns so every pin sees each level and mid flag.
    for (int p = 0; p < 2; p++) begin
      lv = p ? 8'h0F : 8'hF0;
      host.set_bus(lv);
      mid <= p ? 8'hF3 : 8'h0C;
      host.wait_clk(10);
      for (int i = 0; i < 8; i++) exp_loop[2*i +: 2] = mid[i] ? liu_host_port_pkg::LOOP_NONE :
        lv[i] ? liu_host_port_pkg::LOOP_ANALOG : liu_host_port_pkg::LOOP_REMOTE;
      chk("loop_mode", 32'(exp_loop), 32'(loop_mode));
      apb(0, liu_host_port_pkg::ADDR_LOOP, 0);
      chk("loop_reg", 32'(exp_loop), {16'h0000, rdat[15:0]});
    end
    chk("bus_oe_hw", 0, 32'(bus_oe));
    apb(0, 12'h040, 32'hFFFFFFFF);
    chk("unmapped_err", 1, 32'(rerr));
    // Serial mode: a write, then reads on both output edges.
    apb(1, liu_host_port_pkg::ADDR_CTRL, 32'h1);
    host.set_bus(8'h00);
    mid <= 8'h00;
    host.ser_frame(1'b0, 5'h03, 8'hA5, 1'b1, q, oe);
    chk("sdo_oe_write", 0, 32'(oe[1]));
    apb(0, liu_host_port_pkg::ADDR_FILE_BASE + 12'h00C, 0);
    chk("serial_stored", 32'hA5, rdat);
    for (int es = 0; es < 2; es++) begin
      host.ser_frame(1'b1, 5'h03, 8'h00, es[0], q, oe);
      chk("sdo_oe_cmd", 0, 32'(oe[1]));
      chk("sdo_data", 32'hA5, 32'(q));
    end
    // Every parallel style, plain and multiplexed: write then read back.
    for (int m = 2; m < 6; m++) begin
      apb(1, liu_host_port_pkg::ADDR_CTRL, 32'(m));
      a = 5'(m * 5 + 3);
      host.par_xfer(3'(m), 1'b0, a, 8'h3C ^ 8'(m), q, oe);
      chk("bus_oe_write", 0, 32'(oe[0]));
      apb(0, liu_host_port_pkg::ADDR_FILE_BASE + 12'(4 * a), 0);
      chk("par_stored", 32'h3C ^ 32'(m), rdat);
      host.par_xfer(3'(m), 1'b1, a, 8'h00, q, oe);
      chk("par_read", 32'h3C ^ 32'(m), 32'(q));
      chk("bus_oe_read", 1, 32'(oe[0]));
    end
    // Interrupt: one masked event, then each of the four sources unmasked.
    apb(1, liu_host_port_pkg::ADDR_INT_STATUS, 32'h3F);
    apb(1, liu_host_port_pkg::ADDR_INT_MASK, 32'h0);
    int_src <= 4'h2;
    host.wait_clk(4);
    chk("int_masked", 0, 32'(int_n_oe));
    apb(0, liu_host_port_pkg::ADDR_INT_STATUS, 0);
    chk("int_status", 32'h2, rdat & 32'hF);
    apb(1, liu_host_port_pkg::ADDR_INT_MASK, 32'hF);
    for (int s = 0; s < 4; s++) begin
      int_src <= 4'h0;
      apb(1, liu_host_port_pkg::ADDR_INT_STATUS, 32'h3F);
      int_src <= 4'(1 << s);
      host.wait_clk(4);
      chk("int_drive", 32'h2, 32'({int_n_oe, int_n_out}));
      apb(1, liu_host_port_pkg::ADDR_INT_STATUS, 32'(1 << s));
      host.wait_clk(3);
      chk("int_cleared", 0, 32'(int_n_oe));
    end
    tally_and_finish();
  end
endmodule : liu_host_port_tb
